// [src/mpp_pkg.sv]
// Constants and types shared by the MAC pin pull and input status block
package mpp_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [11:0] CFG_IDX        = 12'h456;
  localparam logic [11:0] STATUS_IDX     = 12'h457;
  localparam logic [13:0] CFG_ADDR       = {CFG_IDX, 2'b00};
  localparam logic [13:0] STATUS_ADDR    = {STATUS_IDX, 2'b00};
  localparam int          ADDR_W         = 14;

  // Configuration register field positions
  localparam int          RX_SEL_LSB     = 14;
  localparam int          RX_FORCE_BIT   = 13;
  localparam int          TX_SEL_LSB     = 11;
  localparam int          TX_FORCE_BIT   = 10;
  localparam int          RX_IMP_LSB     = 5;
  localparam int          TX_IMP_LSB     = 0;
  localparam int          SEL_W          = 2;
  localparam int          IMP_W          = 5;
  localparam int          REG_W          = 16;

  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;

  // Status bit that is tied low
  localparam int          STATUS_ZERO_BIT = 12;

  // Pin groups handled by the pull decoder
  localparam int          GRP_RX         = 0;
  localparam int          GRP_TX         = 1;
  localparam int          NUM_GRP        = 2;

  typedef enum logic [1:0] {
    MPP_PULL_NONE = 2'h0,
    MPP_PULL_UP   = 2'h1,
    MPP_PULL_DOWN = 2'h2,
    MPP_PULL_RSVD = 2'h3
  } mpp_pull_e;

endpackage : mpp_pkg

// [src/mpp_pull_if.sv]
// Carrier between the register file and the pull decoder
interface mpp_pull_if;
  logic            [mpp_pkg::NUM_GRP-1:0] force_en;
  mpp_pkg::mpp_pull_e                     sel [mpp_pkg::NUM_GRP];
  logic            [mpp_pkg::NUM_GRP-1:0] pull_up;
  logic            [mpp_pkg::NUM_GRP-1:0] pull_down;

  modport regs (
    output force_en,
    output sel,
    input  pull_up,
    input  pull_down
  );

  modport dec (
    input  force_en,
    input  sel,
    output pull_up,
    output pull_down
  );
endinterface : mpp_pull_if

// [src/mpp_pull_decode.sv]
// Pull selection decoder, one slice per MAC pin group
module mpp_pull_decode (
  mpp_pull_if.dec pull
);

  for (genvar g = 0; g < mpp_pkg::NUM_GRP; g++) begin : g_grp
    always_comb begin
      pull.pull_up[g]   = 1'b0;
      pull.pull_down[g] = 1'b0;
      // No forcing leaves the pad at its own default
      if (pull.force_en[g]) begin
        unique case (pull.sel[g])
          mpp_pkg::MPP_PULL_NONE: ;
          mpp_pkg::MPP_PULL_UP:   pull.pull_up[g]   = 1'b1;
          mpp_pkg::MPP_PULL_DOWN: pull.pull_down[g] = 1'b1;
          // Reserved code drives neither pull, never both
          mpp_pkg::MPP_PULL_RSVD: ;
        endcase
      end
    end
  end

endmodule : mpp_pull_decode

// [src/mpp_sync2.sv]
// Two-stage synchroniser for the sampled pin levels
module mpp_sync2 (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [mpp_pkg::REG_W-1:0] d_i,
  output logic      [mpp_pkg::REG_W-1:0] q_o
);

  logic [mpp_pkg::REG_W-1:0] meta_q;
  logic [mpp_pkg::REG_W-1:0] sync_q;

  for (genvar b = 0; b < mpp_pkg::REG_W; b++) begin : g_bit
    // First stage feeds only the second
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q[b] <= 1'b0;
        sync_q[b] <= 1'b0;
      end else begin
        meta_q[b] <= d_i[b];
        sync_q[b] <= meta_q[b];
      end
    end
  end

  assign q_o = sync_q;

endmodule : mpp_sync2

// [src/mpp_mac_pin_ctrl.sv]
// MAC pin pull, pad impedance and pin input level status, APB slave
module mpp_mac_pin_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic      [31:0] prdata_o,
  output logic             pslverr_o,
  // Direction control from the neighbouring mux registers
  input  wire logic        oe_force_i,
  input  wire logic [15:0] input_mode_i,
  // Raw pin levels in status bit order
  input  wire logic        pin_rx_d3_i,
  input  wire logic        pin_tx_clk_i,
  input  wire logic        pin_tx_en_i,
  input  wire logic [3:0]  pin_txd_i,
  input  wire logic        pin_int_i,
  input  wire logic        pin_clk_out_i,
  input  wire logic        pin_led0_i,
  input  wire logic        pin_rx_clk_i,
  input  wire logic        pin_rx_dv_i,
  input  wire logic        pin_rx_er_i,
  input  wire logic        pin_led1_i,
  input  wire logic        pin_rx_d0_i,
  // Pad controls
  output logic             rx_pull_force_o,
  output logic             rx_pull_up_o,
  output logic             rx_pull_down_o,
  output logic             tx_pull_force_o,
  output logic             tx_pull_up_o,
  output logic             tx_pull_down_o,
  output logic      [4:0]  rx_impedance_o,
  output logic      [4:0]  tx_impedance_o
);

  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [15:0] pin_raw;
  logic [15:0] pin_sync;
  logic [15:0] status_q;
  logic [31:0] prdata_q;
  logic        slverr_q;
  logic [13:0] addr;
  logic        setup;
  logic        access;
  logic        hit_cfg;
  logic        hit_status;
  logic        pull_up_q   [mpp_pkg::NUM_GRP];
  logic        pull_down_q [mpp_pkg::NUM_GRP];

  mpp_pull_if pull ();

  assign addr       = paddr_i[mpp_pkg::ADDR_W-1:0];
  assign setup      = psel_i & ~penable_i;
  assign access     = psel_i & penable_i;
  assign hit_cfg    = (addr == mpp_pkg::CFG_ADDR) &&
                      (paddr_i[31:mpp_pkg::ADDR_W] == '0);
  assign hit_status = (addr == mpp_pkg::STATUS_ADDR) &&
                      (paddr_i[31:mpp_pkg::ADDR_W] == '0);

  // Pin levels gathered into status bit order
  always_comb begin
    pin_raw                           = '0;
    pin_raw[0]                        = pin_rx_d3_i;
    pin_raw[1]                        = pin_tx_clk_i;
    pin_raw[2]                        = pin_tx_en_i;
    pin_raw[6:3]                      = pin_txd_i;
    pin_raw[7]                        = pin_int_i;
    pin_raw[8]                        = pin_clk_out_i;
    pin_raw[9]                        = pin_led0_i;
    pin_raw[10]                       = pin_rx_clk_i;
    pin_raw[11]                       = pin_rx_dv_i;
    pin_raw[mpp_pkg::STATUS_ZERO_BIT] = 1'b0;
    pin_raw[13]                       = pin_rx_er_i;
    pin_raw[14]                       = pin_led1_i;
    pin_raw[15]                       = pin_rx_d0_i;
  end

  mpp_sync2 u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_raw),
    .q_o   (pin_sync)
  );

  // Bits of pins not turned to inputs read zero rather than stale pad data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= mpp_pkg::STATUS_RESET;
    end else begin
      status_q <= pin_sync & ({16{oe_force_i}} & input_mode_i);
    end
  end

  // Configuration write, byte lanes honoured on the low half
  always_comb begin
    cfg_d = cfg_q;
    if (access && pwrite_i && hit_cfg) begin
      if (pstrb_i[0]) begin
        cfg_d[7:0] = pwdata_i[7:0];
      end
      if (pstrb_i[1]) begin
        cfg_d[15:8] = pwdata_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= mpp_pkg::CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Read data and error captured in setup so access needs no wait state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= '0;
      slverr_q <= ~(hit_cfg | hit_status);
      if (!pwrite_i && hit_cfg) begin
        prdata_q[15:0] <= cfg_q;
      end
      if (!pwrite_i && hit_status) begin
        prdata_q[15:0] <= status_q;
      end
    end
  end

  // Status write is accepted without error and has no effect
  assign pready_o  = 1'b1;
  assign prdata_o  = prdata_q;
  assign pslverr_o = access & slverr_q;

  // Pull decode
  assign pull.force_en[mpp_pkg::GRP_RX] =
    cfg_q[mpp_pkg::RX_FORCE_BIT];
  assign pull.force_en[mpp_pkg::GRP_TX] =
    cfg_q[mpp_pkg::TX_FORCE_BIT];
  assign pull.sel[mpp_pkg::GRP_RX] = mpp_pkg::mpp_pull_e'(
    cfg_q[mpp_pkg::RX_SEL_LSB +: mpp_pkg::SEL_W]);
  assign pull.sel[mpp_pkg::GRP_TX] = mpp_pkg::mpp_pull_e'(
    cfg_q[mpp_pkg::TX_SEL_LSB +: mpp_pkg::SEL_W]);

  mpp_pull_decode u_dec (
    .pull (pull.dec)
  );

  // Registered pad controls keep glitches off the pads
  for (genvar g = 0; g < mpp_pkg::NUM_GRP; g++) begin : g_pad
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        pull_up_q[g]   <= 1'b0;
        pull_down_q[g] <= 1'b0;
      end else begin
        pull_up_q[g]   <= pull.pull_up[g];
        pull_down_q[g] <= pull.pull_down[g];
      end
    end
  end

  assign rx_pull_force_o = cfg_q[mpp_pkg::RX_FORCE_BIT];
  assign tx_pull_force_o = cfg_q[mpp_pkg::TX_FORCE_BIT];
  assign rx_pull_up_o    = pull_up_q[mpp_pkg::GRP_RX];
  assign rx_pull_down_o  = pull_down_q[mpp_pkg::GRP_RX];
  assign tx_pull_up_o    = pull_up_q[mpp_pkg::GRP_TX];
  assign tx_pull_down_o  = pull_down_q[mpp_pkg::GRP_TX];
  assign rx_impedance_o  =
    cfg_q[mpp_pkg::RX_IMP_LSB +: mpp_pkg::IMP_W];
  assign tx_impedance_o  =
    cfg_q[mpp_pkg::TX_IMP_LSB +: mpp_pkg::IMP_W];

endmodule : mpp_mac_pin_ctrl

// [dv/mpp_mac_model.sv]
// MAC side model driving the sensed interface pin levels
module mpp_mac_model (
  input  wire logic        drive_i,
  input  wire logic [15:0] lvl_i,
  output logic      [15:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_q = '0;
  // Released pins show the inverse so stale values are never mistaken
  always_comb pins_o = drive_i ? lvl_i : ~last_q;
  always @(lvl_i) if (drive_i) last_q = lvl_i;
endmodule // mpp_mac_model

// [dv/mpp_monitor.sv]
// Assertions on the ports of the MAC pin control block
module mpp_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic        rx_pull_force_o,
  input wire logic        rx_pull_up_o,
  input wire logic        rx_pull_down_o,
  input wire logic        tx_pull_force_o,
  input wire logic        tx_pull_up_o,
  input wire logic        tx_pull_down_o,
  input wire logic [4:0]  rx_impedance_o,
  input wire logic [4:0]  tx_impedance_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic acc, hc, hs;
  assign acc = psel_i & penable_i;
  assign hc = paddr_i == 32'(mpp_pkg::CFG_ADDR);
  assign hs = paddr_i == 32'(mpp_pkg::STATUS_ADDR);
  apb_ready_a: assert property (acc |-> pready_o)
    else $error("no ready in access");
  apb_error_a: assert property (acc |-> pslverr_o == !(hc || hs))
    else $error("error flag wrong");
  upper_zero_a: assert property (
    acc && !pwrite_i |-> prdata_o[31:16] == 16'h0)
    else $error("upper read bits set");
  zero_bit_a: assert property (
    acc && !pwrite_i && hs |-> !prdata_o[12])
    else $error("status bit 12 set");
  rx_pull_a: assert property (
    (rx_pull_up_o || rx_pull_down_o) |-> $past(rx_pull_force_o))
    else $error("rx pull without force");
  tx_pull_a: assert property (
    (tx_pull_up_o || tx_pull_down_o) |-> $past(tx_pull_force_o))
    else $error("tx pull without force");
  pull_excl_a: assert property (
    !(rx_pull_up_o && rx_pull_down_o) && !(tx_pull_up_o && tx_pull_down_o))
    else $error("pull up and down together");
  imp_write_a: assert property (
    acc && pwrite_i && hc && pstrb_i == 4'hF |=>
    rx_impedance_o == $past(pwdata_i[9:5]) &&
    tx_impedance_o == $past(pwdata_i[4:0]))
    else $error("impedance not written");
  imp_hold_a: assert property (
    !(acc && pwrite_i) |=> $stable(rx_impedance_o) && $stable(tx_impedance_o))
    else $error("impedance changed without write");
  cover property (acc && pslverr_o);
  cover property (rx_pull_up_o);
  cover property (tx_pull_down_o);
endmodule // mpp_monitor
bind mpp_mac_pin_ctrl mpp_monitor mon (.*);

// [dv/tb_top.sv]
// Self-checking bench for the MAC pin control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CA = 32'(mpp_pkg::CFG_ADDR);
  localparam logic [31:0] SA = 32'(mpp_pkg::STATUS_ADDR);
  logic        clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic        oe = 0, err, rdy, se, rf, ru, rd, tf, tu, td;
  logic [31:0] paddr = 0, pwdata = 0, prd, r;
  logic [15:0] mode = 0, lvl = 0, pins, v, ex;
  logic [4:0]  ri, ti;
  logic [1:0]  ts;
  logic [3:0]  strb = 4'hF;
  int          num_errors = 0, num_checks = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  mpp_mac_model pm (.drive_i(oe), .lvl_i(lvl), .pins_o(pins));
  mpp_mac_pin_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(strb), .pready_o(rdy), .prdata_o(prd),
    .pslverr_o(se), .oe_force_i(oe), .input_mode_i(mode),
    .pin_rx_d3_i(pins[0]), .pin_tx_clk_i(pins[1]), .pin_tx_en_i(pins[2]),
    .pin_txd_i(pins[6:3]), .pin_int_i(pins[7]), .pin_clk_out_i(pins[8]),
    .pin_led0_i(pins[9]), .pin_rx_clk_i(pins[10]), .pin_rx_dv_i(pins[11]),
    .pin_rx_er_i(pins[13]), .pin_led1_i(pins[14]), .pin_rx_d0_i(pins[15]),
    .rx_pull_force_o(rf), .rx_pull_up_o(ru), .rx_pull_down_o(rd),
    .tx_pull_force_o(tf), .tx_pull_up_o(tu), .tx_pull_down_o(td),
    .rx_impedance_o(ri), .tx_impedance_o(ti));
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do @(posedge clk_i); while (rdy !== 1'b1);
    r = prd;
    err = se;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    apb(0, CA, 0);
    chk("cfg reset", 0, r);
    // Every pull code on both groups, force toggled in opposite phase
    for (int s = 0; s < 8; s++) begin
      ts = ~s[1:0];
      v = {s[1:0], s[2], ts, ~s[2], 5'(s * 9 + 3), 5'(31 - s * 4)};
      apb(1, CA, {16'h0, v});
      repeat (2) @(posedge clk_i);
      ex = 16'({s[2], s[2] & (s[1:0] == 2'h1), s[2] & (s[1:0] == 2'h2),
        ~s[2], ~s[2] & (ts == 2'h1), ~s[2] & (ts == 2'h2)});
      chk("rx pad", 32'(ex[5:3]), 32'({rf, ru, rd}));
      chk("tx pad", 32'(ex[2:0]), 32'({tf, tu, td}));
      chk("rx imp", 32'(v[9:5]), 32'(ri));
      chk("tx imp", 32'(v[4:0]), 32'(ti));
      apb(0, CA, 0);
      chk("cfg", 32'(v), r);
    end
    apb(1, 32'h1160, 32'hFFFF);
    chk("unmapped err", 1, 32'(err));
    apb(1, SA, 32'hFFFF);
    chk("status write err", 0, 32'(err));
    apb(0, CA, 0);
    chk("cfg kept", 32'(v), r);
    // Lane 0 only: the high byte must survive the write
    strb <= 4'h1;
    apb(1, CA, 32'hFFFF);
    strb <= 4'hF;
    apb(0, CA, 0);
    chk("cfg lane", 32'({v[15:8], 8'hFF}), r);
    // Level patterns, partial input mode, then direction force off
    for (int i = 0; i < 4; i++) begin
      oe <= (i < 3);
      lvl <= (i == 1) ? 16'hA5C3 : (i == 2) ? 16'h5A3C : 16'hFFFF;
      mode <= (i == 2) ? 16'h0FF0 : 16'hFFFF;
      repeat (5) @(posedge clk_i);
      ex = (i < 3) ? lvl & mode & 16'hEFFF : 16'h0;
      apb(0, SA, 0);
      chk("status", 32'(ex), r);
    end
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    apb(0, CA, 0);
    chk("cfg rereset", 0, r);
    chk("pads rereset", 0, 32'({rf, ru, rd, tf, tu, td, ri, ti}));
    final_report();
  end
endmodule // tb_top
